// [src/slc_line_ctrl.sv]
// single-line serial controller core: control decode, receive, compare, transmit
`timescale 1ns/100ps
`include "slc_map.svh"
module slc_line_ctrl #(
  parameter int NST = 4,
  parameter int NCAM = 4
) (
  input wire logic i_ref_clk, // host side clock
  input wire logic i_rst_n, // synchronous reset
  input wire logic i_line_clk, // modem bit clock
  input wire logic i_ctl_stb, // control word strobe
  input wire logic [15:0] i_ctl_word, // control word
  input wire logic i_write_stb, // write word strobe
  input wire logic [15:0] i_write_word, // word to transmit
  output logic o_tx_busy, // transmit word in progress
  input wire logic i_read_stb, // host takes receive word
  output logic [15:0] o_read_word, // receive word
  output logic o_rx_word_ready, // receive word waiting
  input wire logic i_io_reset, // i/o reset pulse
  input wire logic i_cond_jump, // conditional jump order issued
  input wire logic i_table_fetch, // device table entry fetch
  output logic o_jump_condition_met, // jump answer pulse
  output logic o_device_end_request, // device end to channel
  input wire logic i_xfer_error, // channel transfer error
  input wire logic i_int_clear, // clear pending interrupts
  input wire logic i_int_mask, // interrupt mask flag
  output logic o_int_req, // interrupt request
  output logic [2:0] o_int_pending, // status, error, data
  input wire logic [NST-1:0] i_status_line, // device status lines
  input wire logic i_rx_data, // serial receive data
  output logic o_tx_data // serial transmit data
);
  import slc_pkg::*;

  localparam int CW = 6 + NCAM * 9;

  logic [15:0] fmt;
  logic [15:0] rxtx;
  logic int_en;
  logic clr;
  logic hunt_tgl;
  logic [7:0] cam_chr [NCAM];
  logic [3:0] cam_fn [NCAM];
  logic [3:0] fn_hit [NCAM];
  logic [NCAM-1:0] sel;
  logic [CW-1:0] cfg_src;
  logic [CW-1:0] cfg_s1;
  logic [CW-1:0] cfg_s2;

  assign clr = i_io_reset | (i_ctl_stb & (i_ctl_word[15:12] == `SLC_CW_CLEAR));

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      fmt <= `SLC_FORMAT_RST;
      rxtx <= `SLC_RXTX_RST;
      int_en <= 1'b0;
    end
    else if (i_ctl_stb)
    begin
      unique case (i_ctl_word[15:12])
        `SLC_CW_FORMAT: fmt <= i_ctl_word;
        `SLC_CW_RXTX: rxtx <= i_ctl_word;
        `SLC_CW_INTCTL: int_en <= i_ctl_word[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      hunt_tgl <= 1'b0;
    else if (clr)
      hunt_tgl <= ~hunt_tgl;
  end

  // associate memory: write, compare and function select per entry
  logic arr;
  logic [7:0] rx_chr;
  logic [3:0] fn_reg;
  logic [3:0] fn_or;
  generate
    for (genvar g = 0; g < NCAM; g++)
    begin : g_cam
      localparam logic [1:0] IDX = 2'(g);
      always_ff @(posedge i_ref_clk)
      begin
        if (!i_rst_n)
        begin
          cam_chr[g] <= 8'h00;
          cam_fn[g] <= 4'h0;
        end
        else if (i_ctl_stb && i_ctl_word[15:14] == `SLC_CW_ASSOC
                 && i_ctl_word[13:12] == IDX)
        begin
          cam_chr[g] <= i_ctl_word[7:0];
          cam_fn[g] <= i_ctl_word[`SLC_F_FN+3:`SLC_F_FN];
        end
      end
      always_ff @(posedge i_ref_clk)
      begin
        if (!i_rst_n)
          sel[g] <= 1'b0;
        else
          sel[g] <= arr & (rx_chr == cam_chr[g]);
      end
      assign fn_hit[g] = sel[g] ? cam_fn[g] : 4'h0;
      assign cfg_src[6+g*9 +: 9] = {cam_fn[g][`SLC_FN_DISC], cam_chr[g]};
    end
  endgenerate

  always_comb
  begin
    fn_or = 4'h0;
    for (int k = 0; k < NCAM; k++)
      fn_or = fn_or | fn_hit[k];
  end

  assign cfg_src[5:0] = {fmt[`SLC_F_PAR], fmt[`SLC_F_ODD], fmt[`SLC_F_ECHO],
                         fmt[`SLC_F_ASYNC], fmt[`SLC_F_LEN+1:`SLC_F_LEN]};

  // ---------------- link domain ----------------
  logic lrst1;
  logic line_rst_n;
  logic h1;
  logic h2;
  logic h3;
  logic l_async;
  logic l_echo;
  logic l_odd;
  logic l_par;
  logic [3:0] l_len;
  logic [7:0] l_mask;
  logic rx_bit;
  slc_rx_state_t rx_st;
  logic [7:0] rx_sh;
  logic [7:0] next_rx_sh;
  logic [3:0] rx_cnt;
  logic rx_perr_b;
  logic rx_tgl;
  logic [7:0] rx_out;
  logic rx_out_perr;
  logic rx_out_brk;
  logic hunt_hit;

  function automatic logic [7:0] slc_align(input logic [7:0] s, input logic [3:0] n);
    slc_align = s >> (`SLC_MAX_LEN - n);
  endfunction

  always_ff @(posedge i_line_clk)
  begin
    lrst1 <= i_rst_n;
    line_rst_n <= lrst1;
  end

  always_ff @(posedge i_line_clk)
  begin
    cfg_s1 <= cfg_src;
    cfg_s2 <= cfg_s1;
    h1 <= hunt_tgl;
    h2 <= h1;
    h3 <= h2;
    rx_bit <= i_rx_data;
  end

  assign l_len = {2'b00, cfg_s2[1:0]} + `SLC_MIN_LEN;
  assign l_async = cfg_s2[2];
  assign l_echo = cfg_s2[3];
  assign l_odd = cfg_s2[4];
  assign l_par = cfg_s2[5];
  assign l_mask = 8'hff >> (`SLC_MAX_LEN - l_len);
  assign next_rx_sh = {rx_bit, rx_sh[7:1]};

  always_comb
  begin
    hunt_hit = 1'b0;
    for (int k = 0; k < NCAM; k++)
      if (cfg_s2[6+k*9+8] && slc_align(next_rx_sh, l_len) == (cfg_s2[6+k*9 +: 8] & l_mask))
        hunt_hit = 1'b1;
  end

  always_ff @(posedge i_line_clk)
  begin
    if (!line_rst_n || (h2 ^ h3))
    begin
      rx_st <= slc_rx_idle;
      rx_sh <= 8'h00;
      rx_cnt <= 4'h0;
      rx_perr_b <= 1'b0;
      rx_tgl <= 1'b0;
      rx_out <= 8'h00;
      rx_out_perr <= 1'b0;
      rx_out_brk <= 1'b0;
    end
    else
    begin
      unique case (rx_st)
        slc_rx_idle:
        begin
          rx_cnt <= 4'h0;
          if (l_async)
          begin
            if (!rx_bit)
              rx_st <= slc_rx_data;
          end
          else
          begin
            rx_sh <= next_rx_sh;
            if (hunt_hit)
              rx_st <= slc_rx_par;
          end
        end
        slc_rx_data:
        begin
          rx_sh <= next_rx_sh;
          rx_cnt <= rx_cnt + 4'h1;
          if (rx_cnt == l_len - 4'h1)
            rx_st <= slc_rx_par;
        end
        slc_rx_par:
        begin
          rx_perr_b <= l_par & ((^(slc_align(rx_sh, l_len)) ^ rx_bit) != l_odd);
          rx_cnt <= 4'h0;
          if (l_async)
            rx_st <= slc_rx_stop;
          else
          begin
            rx_out <= slc_align(rx_sh, l_len);
            rx_out_perr <= l_par & ((^(slc_align(rx_sh, l_len)) ^ rx_bit) != l_odd);
            rx_out_brk <= 1'b0;
            rx_tgl <= ~rx_tgl;
            rx_st <= slc_rx_data;
          end
        end
        slc_rx_stop:
        begin
          rx_out <= slc_align(rx_sh, l_len);
          rx_out_perr <= rx_perr_b | ~rx_bit;
          rx_out_brk <= ~rx_bit & (slc_align(rx_sh, l_len) == 8'h00);
          rx_tgl <= ~rx_tgl;
          rx_st <= rx_bit ? slc_rx_idle : slc_rx_mark;
        end
        slc_rx_mark:
          if (rx_bit)
            rx_st <= slc_rx_idle;
      endcase
    end
  end

  // transmitter on the modem clock
  logic tq1;
  logic tq2;
  logic tx_req_tgl;
  logic tx_ack;
  logic [7:0] tx_byte;
  slc_tx_state_t tx_st;
  logic [7:0] tx_sh;
  logic [3:0] tx_cnt;
  logic tx_par;
  logic tx_line;

  always_ff @(posedge i_line_clk)
  begin
    tq1 <= tx_req_tgl;
    tq2 <= tq1;
  end

  always_ff @(posedge i_line_clk)
  begin
    if (!line_rst_n)
    begin
      tx_st <= slc_tx_idle;
      tx_sh <= 8'h00;
      tx_cnt <= 4'h0;
      tx_par <= 1'b0;
      tx_line <= 1'b1;
      tx_ack <= 1'b0;
    end
    else
    begin
      unique case (tx_st)
        slc_tx_idle:
        begin
          tx_line <= 1'b1;
          if (tq2 != tx_ack)
          begin
            tx_sh <= tx_byte;
            tx_par <= l_odd;
            tx_cnt <= 4'h0;
            tx_ack <= tq2;
            tx_st <= l_async ? slc_tx_start : slc_tx_data;
          end
        end
        slc_tx_start:
        begin
          tx_line <= 1'b0;
          tx_st <= slc_tx_data;
        end
        slc_tx_data:
        begin
          tx_line <= tx_sh[0];
          tx_par <= tx_par ^ tx_sh[0];
          tx_sh <= {1'b0, tx_sh[7:1]};
          tx_cnt <= tx_cnt + 4'h1;
          if (tx_cnt == l_len - 4'h1)
            tx_st <= slc_tx_par;
        end
        slc_tx_par:
        begin
          tx_line <= tx_par;
          tx_cnt <= 4'h0;
          if (l_async)
            tx_st <= slc_tx_stop;
          else if (tq2 != tx_ack)
          begin
            tx_sh <= tx_byte;
            tx_par <= l_odd;
            tx_ack <= tq2;
            tx_st <= slc_tx_data;
          end
          else
            tx_st <= slc_tx_idle;
        end
        slc_tx_stop:
        begin
          tx_line <= 1'b1;
          tx_st <= slc_tx_idle;
        end
        default: tx_st <= slc_tx_idle;
      endcase
    end
  end

  always_ff @(posedge i_line_clk)
  begin
    if (!line_rst_n)
      o_tx_data <= 1'b1;
    else
      o_tx_data <= l_echo ? rx_bit : tx_line;
  end

  // ---------------- host domain ----------------
  logic r1;
  logic r2;
  logic r3;
  logic a1;
  logic a2;
  logic a3;
  logic arr_d;
  logic act;
  logic c_perr;
  logic c_brk;
  logic [7:0] c_chr;
  logic receive_byte_select_toggle;
  logic transmit_byte_select_toggle;
  logic [7:0] asm_hi;
  logic word_done;
  logic overrun;
  logic tx_need;
  logic jump_pend;
  logic [NST-1:0] st1;
  logic [NST-1:0] st2;
  logic [NST-1:0] st3;
  logic dpend;
  logic epend;
  logic spend;

  always_ff @(posedge i_ref_clk)
  begin
    r1 <= rx_tgl;
    r2 <= r1;
    r3 <= r2;
    a1 <= tx_ack;
    a2 <= a1;
    a3 <= a2;
    st1 <= i_status_line;
    st2 <= st1;
    st3 <= st2;
  end

  assign arr = r2 ^ r3;
  assign rx_chr = rx_out;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      arr_d <= 1'b0;
      act <= 1'b0;
      c_chr <= 8'h00;
      c_perr <= 1'b0;
      c_brk <= 1'b0;
      fn_reg <= 4'h0;
    end
    else
    begin
      arr_d <= arr;
      act <= arr_d;
      if (arr)
      begin
        c_chr <= rx_out;
        c_perr <= rx_out_perr;
        c_brk <= rx_out_brk;
      end
      if (arr_d)
        fn_reg <= fn_or;
    end
  end

  // word assembly
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || clr)
    begin
      receive_byte_select_toggle <= 1'b0;
      asm_hi <= 8'h00;
      o_read_word <= 16'h0000;
      o_rx_word_ready <= 1'b0;
      word_done <= 1'b0;
      overrun <= 1'b0;
    end
    else
    begin
      word_done <= 1'b0;
      overrun <= 1'b0;
      if (act && !c_brk && !fn_reg[`SLC_FN_DISC])
      begin
        if (fmt[`SLC_F_PACK] && !receive_byte_select_toggle)
        begin
          asm_hi <= c_chr;
          receive_byte_select_toggle <= 1'b1;
        end
        else
        begin
          receive_byte_select_toggle <= 1'b0;
          o_read_word <= fmt[`SLC_F_PACK] ? {asm_hi, c_chr} : {8'h00, c_chr};
          o_rx_word_ready <= 1'b1;
          word_done <= 1'b1;
          overrun <= o_rx_word_ready & ~i_read_stb;
        end
      end
      else if (i_read_stb)
        o_rx_word_ready <= 1'b0;
    end
  end

  // channel answers
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || clr)
    begin
      jump_pend <= 1'b0;
      o_jump_condition_met <= 1'b0;
      o_device_end_request <= 1'b0;
    end
    else
    begin
      o_jump_condition_met <= i_table_fetch & jump_pend & i_cond_jump;
      if (act && fn_reg[`SLC_FN_JUMP])
        jump_pend <= 1'b1;
      else if (i_table_fetch)
        jump_pend <= 1'b0;
      if (act && fn_reg[`SLC_FN_DEVEND])
        o_device_end_request <= 1'b1;
      else if (i_read_stb)
        o_device_end_request <= 1'b0;
    end
  end

  // transmit word handling; second byte waits here while the first is on the line
  logic [7:0] asm_tx;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_tx_busy <= 1'b0;
      tx_byte <= 8'h00;
      tx_req_tgl <= 1'b0;
      transmit_byte_select_toggle <= 1'b0;
      tx_need <= 1'b0;
    end
    else
    begin
      tx_need <= 1'b0;
      if (i_write_stb && !o_tx_busy)
      begin
        o_tx_busy <= 1'b1;
        tx_byte <= fmt[`SLC_F_UNPACK] ? i_write_word[15:8] : i_write_word[7:0];
        asm_tx <= i_write_word[7:0];
        transmit_byte_select_toggle <= fmt[`SLC_F_UNPACK];
        tx_req_tgl <= ~tx_req_tgl;
      end
      else if (a2 ^ a3)
      begin
        if (transmit_byte_select_toggle)
        begin
          tx_byte <= asm_tx;
          transmit_byte_select_toggle <= 1'b0;
          tx_req_tgl <= ~tx_req_tgl;
        end
        else
        begin
          o_tx_busy <= 1'b0;
          tx_need <= 1'b1;
        end
      end
    end
  end

  // interrupt pending flags; a new event beats a clear in the same cycle
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      dpend <= 1'b0;
      epend <= 1'b0;
      spend <= 1'b0;
      o_int_req <= 1'b0;
    end
    else
    begin
      if ((act & fn_reg[`SLC_FN_INT]) | (tx_need & rxtx[`SLC_F_TXIE])
          | (word_done & rxtx[`SLC_F_RXIE]) | (act & c_brk))
        dpend <= 1'b1;
      else if (i_int_clear || clr)
        dpend <= 1'b0;
      if (overrun | (act & c_perr & ~c_brk) | i_xfer_error)
        epend <= 1'b1;
      else if (i_int_clear || clr)
        epend <= 1'b0;
      if (|((st2 ^ st3) & rxtx[`SLC_F_STIE +: NST]))
        spend <= 1'b1;
      else if (i_int_clear || clr)
        spend <= 1'b0;
      o_int_req <= (dpend | epend | spend) & int_en & i_int_mask;
    end
  end

  assign o_int_pending = {spend, epend, dpend};

endmodule

// [src/slc_map.svh]
// offsets, field positions and reset values of the serial line controller
`ifndef SLC_MAP_SVH
`define SLC_MAP_SVH
// control word destination codes, top nibble of the word (top two bits for associate entries)
`define SLC_CW_FORMAT 4'h1
`define SLC_CW_RXTX 4'h2
`define SLC_CW_ASSOC 2'h1
`define SLC_CW_CLEAR 4'h8
`define SLC_CW_INTCTL 4'h9
// format word fields (bit 15 is printed bit 0)
`define SLC_F_LEN 0
`define SLC_F_ASYNC 2
`define SLC_F_PACK 3
`define SLC_F_UNPACK 4
`define SLC_F_ECHO 5
`define SLC_F_ODD 9
`define SLC_F_PAR 10
// receive/transmit control word fields
`define SLC_F_RXIE 0
`define SLC_F_TXIE 1
`define SLC_F_STIE 2
// associate entry: function nibble position and function bits
`define SLC_F_FN 8
`define SLC_FN_JUMP 0
`define SLC_FN_DEVEND 1
`define SLC_FN_INT 2
`define SLC_FN_DISC 3
// reset values
`define SLC_FORMAT_RST 16'h0003
`define SLC_RXTX_RST 16'h0000
// shortest character and widest character
`define SLC_MIN_LEN 4'h5
`define SLC_MAX_LEN 4'h8
`endif

// [src/slc_pkg.sv]
// types shared by the serial line controller
package slc_pkg;
  typedef enum logic [2:0]
  {
    slc_rx_idle = 3'b000,
    slc_rx_data = 3'b001,
    slc_rx_par = 3'b011,
    slc_rx_stop = 3'b010,
    slc_rx_mark = 3'b110
  } slc_rx_state_t;
  typedef enum logic [2:0]
  {
    slc_tx_idle = 3'b000,
    slc_tx_start = 3'b001,
    slc_tx_data = 3'b011,
    slc_tx_par = 3'b010,
    slc_tx_stop = 3'b110
  } slc_tx_state_t;
endpackage

// [dv/slc_modem.sv]
// modem model: free-running bit clock, serial source and serial sink
`timescale 1ns/100ps
module slc_modem (
  output logic o_line_clk, // modem bit clock
  output logic o_rx_data, // serial data towards the controller
  input wire logic i_tx_data // serial data from the controller
);
  initial
  begin
    o_line_clk = 1'b0;
    o_rx_data = 1'b1;
    #3.3;
    forever #7.5 o_line_clk = ~o_line_clk;
  end
  // one frame, data lsb first, parity bit always present
  task automatic send(input logic [7:0] c, input int len, input bit asy, input bit odd);
    logic p;
    p = odd;
    if (asy)
    begin
      @(negedge o_line_clk);
      o_rx_data = 1'b0;
    end
    for (int i = 0; i < len; i++)
    begin
      @(negedge o_line_clk);
      o_rx_data = c[i];
      p = p ^ c[i];
    end
    @(negedge o_line_clk);
    o_rx_data = p;
    if (asy)
    begin
      @(negedge o_line_clk);
      o_rx_data = 1'b1;
    end
  endtask
  // async sink, samples mid-bit on the falling edge
  task automatic get(output logic [7:0] c, output logic p, output logic stp, input int len);
    c = 8'h00;
    do @(negedge o_line_clk); while (i_tx_data !== 1'b0);
    for (int i = 0; i < len; i++)
    begin
      @(negedge o_line_clk);
      c[i] = i_tx_data;
    end
    @(negedge o_line_clk);
    p = i_tx_data;
    @(negedge o_line_clk);
    stp = i_tx_data;
  endtask
endmodule

// [dv/slc_line_ctrl_sva.sv]
// port checker for the serial line controller
`timescale 1ns/100ps
`include "slc_map.svh"
module slc_line_ctrl_sva (
  input wire logic i_ref_clk, // host clock
  input wire logic i_rst_n, // synchronous reset
  input wire logic i_ctl_stb, // control strobe
  input wire logic [15:0] i_ctl_word, // control word
  input wire logic i_write_stb, // write strobe
  input wire logic o_tx_busy, // transmit busy
  input wire logic i_read_stb, // read strobe
  input wire logic o_rx_word_ready, // word waiting
  input wire logic i_io_reset, // i/o reset
  input wire logic i_cond_jump, // conditional jump
  input wire logic i_table_fetch, // table fetch
  input wire logic o_jump_condition_met, // jump answer
  input wire logic i_xfer_error, // transfer error
  input wire logic i_int_clear, // clear pending
  input wire logic i_int_mask, // mask flag
  input wire logic o_int_req, // interrupt request
  input wire logic [2:0] o_int_pending // pending flags
);
  logic clr;
  logic fetch_j;
  assign clr = i_int_clear | i_io_reset | (i_ctl_stb & (i_ctl_word[15:12] == `SLC_CW_CLEAR));
  assign fetch_j = i_table_fetch & i_cond_jump;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_write;
    i_write_stb && !o_tx_busy;
  endsequence
  sequence s_masked;
    !i_int_mask [*2];
  endsequence
  property p_jump;
    o_jump_condition_met |-> $past(fetch_j);
  endproperty
  a_jump: assert property (p_jump) else $error("jump answer without fetch");
  property p_jump_neg;
    i_table_fetch && !i_cond_jump |=> !o_jump_condition_met;
  endproperty
  a_jump_neg: assert property (p_jump_neg) else $error("jump without order");
  property p_req;
    o_int_req |-> $past(i_int_mask) && ($past(o_int_pending) != 3'h0);
  endproperty
  a_req: assert property (p_req) else $error("request without cause");
  property p_nomask;
    s_masked |-> !o_int_req;
  endproperty
  a_nomask: assert property (p_nomask) else $error("request while masked");
  property p_xerr;
    i_xfer_error |=> o_int_pending[1];
  endproperty
  a_xerr: assert property (p_xerr) else $error("transfer error lost");
  property p_err_hold;
    o_int_pending[1] && !clr |=> o_int_pending[1];
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped");
  property p_data_hold;
    o_int_pending[0] && !clr |=> o_int_pending[0];
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data flag dropped");
  property p_busy;
    s_write |=> o_tx_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("write did not start");
  property p_ready_clr;
    i_read_stb |=> !o_rx_word_ready;
  endproperty
  a_ready_clr: assert property (p_ready_clr) else $error("ready kept after read");
endmodule
bind slc_line_ctrl slc_line_ctrl_sva sva_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_ctl_stb(i_ctl_stb), .i_ctl_word(i_ctl_word), .i_write_stb(i_write_stb),
  .o_tx_busy(o_tx_busy), .i_read_stb(i_read_stb), .o_rx_word_ready(o_rx_word_ready),
  .i_io_reset(i_io_reset), .i_cond_jump(i_cond_jump), .i_table_fetch(i_table_fetch),
  .o_jump_condition_met(o_jump_condition_met), .i_xfer_error(i_xfer_error),
  .i_int_clear(i_int_clear), .i_int_mask(i_int_mask), .o_int_req(o_int_req),
  .o_int_pending(o_int_pending));

// [dv/testbench.sv]
// self-checking bench for the serial line controller
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("[FAIL] %s exp %h got %h", nm, exp, got); \
    end \
  end
module testbench;
  logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_ctl_stb = 1'b0, i_write_stb = 1'b0;
  logic i_read_stb = 1'b0, i_io_reset = 1'b0, i_cond_jump = 1'b0, i_table_fetch = 1'b0;
  logic i_xfer_error = 1'b0, i_int_clear = 1'b0, i_int_mask = 1'b0;
  logic [15:0] i_ctl_word = 16'h0000, i_write_word = 16'h0000;
  logic [3:0] i_status_line = 4'h0;
  logic i_line_clk, i_rx_data, o_tx_data, o_tx_busy, o_rx_word_ready;
  logic o_jump_condition_met, o_device_end_request, o_int_req;
  logic [15:0] o_read_word;
  logic [2:0] o_int_pending;
  int fails = 0;
  int n_checks = 0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  slc_line_ctrl #(.NST(4), .NCAM(4)) slc_line_ctrl_i (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_line_clk(i_line_clk), .i_ctl_stb(i_ctl_stb),
    .i_ctl_word(i_ctl_word), .i_write_stb(i_write_stb), .i_write_word(i_write_word),
    .o_tx_busy(o_tx_busy), .i_read_stb(i_read_stb), .o_read_word(o_read_word),
    .o_rx_word_ready(o_rx_word_ready), .i_io_reset(i_io_reset), .i_cond_jump(i_cond_jump),
    .i_table_fetch(i_table_fetch), .o_jump_condition_met(o_jump_condition_met),
    .o_device_end_request(o_device_end_request), .i_xfer_error(i_xfer_error),
    .i_int_clear(i_int_clear), .i_int_mask(i_int_mask), .o_int_req(o_int_req),
    .o_int_pending(o_int_pending), .i_status_line(i_status_line),
    .i_rx_data(i_rx_data), .o_tx_data(o_tx_data));
  slc_modem slc_modem_i (.o_line_clk(i_line_clk), .o_rx_data(i_rx_data),
    .i_tx_data(o_tx_data));
  task automatic end_sim;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // control word, then time for the line side to pick it up
  task automatic ctl(input logic [15:0] w);
    @(negedge i_ref_clk);
    i_ctl_word = w;
    i_ctl_stb = 1'b1;
    @(negedge i_ref_clk);
    i_ctl_stb = 1'b0;
    repeat (4) @(negedge i_ref_clk);
  endtask
  // 0 read, 1 fetch, 2 transfer error, 3 clear, 4 i/o reset
  task automatic pulse(input int k);
    @(negedge i_ref_clk);
    case (k)
      0: i_read_stb = 1'b1;
      1: i_table_fetch = 1'b1;
      2: i_xfer_error = 1'b1;
      3: i_int_clear = 1'b1;
      default: i_io_reset = 1'b1;
    endcase
    @(negedge i_ref_clk);
    {i_read_stb, i_table_fetch, i_xfer_error, i_int_clear, i_io_reset} = 5'h00;
  endtask
  task automatic rxw(input logic [7:0] c, input logic [15:0] exp);
    slc_modem_i.send(c, 8, 1'b1, 1'b0);
    for (int n = 0; n < 100 && o_rx_word_ready !== 1'b1; n++) @(negedge i_ref_clk);
    `CHK("read word", exp, o_read_word)
    pulse(0);
  endtask
  task automatic wr(input logic [15:0] w);
    @(negedge i_ref_clk);
    i_write_word = w;
    i_write_stb = 1'b1;
    @(negedge i_ref_clk);
    i_write_stb = 1'b0;
    `CHK("busy", 1'b1, o_tx_busy)
  endtask
  initial
  begin
    #300000;
    fails++;
    end_sim();
  end
  initial
  begin
    logic [7:0] c;
    logic p, s;
    int z;
    repeat (8) @(negedge i_ref_clk);
    `CHK("tx idle", 1'b1, o_tx_data)
    `CHK("int idle", 1'b0, o_int_req)
    i_rst_n = 1'b1;
    #100;
    ctl(16'h1007);
    ctl(16'h4816);
    ctl(16'h7755);
    ctl(16'h9001);
    rxw(8'ha5, 16'h00a5);
    slc_modem_i.send(8'h16, 8, 1'b1, 1'b0);
    repeat (12) @(negedge i_ref_clk);
    `CHK("discarded", 1'b0, o_rx_word_ready)
    rxw(8'h41, 16'h0041);
    ctl(16'h100f);
    slc_modem_i.send(8'h12, 8, 1'b1, 1'b0);
    rxw(8'h34, 16'h1234);
    ctl(16'h1007);
    i_int_mask = 1'b1;
    i_cond_jump = 1'b1;
    slc_modem_i.send(8'h55, 8, 1'b1, 1'b0);
    for (z = 0; z < 100 && o_rx_word_ready !== 1'b1; z++) @(negedge i_ref_clk);
    repeat (3) @(negedge i_ref_clk);
    `CHK("device end", 1'b1, o_device_end_request)
    `CHK("data pend", 1'b1, o_int_pending[0])
    `CHK("int req", 1'b1, o_int_req)
    pulse(1);
    `CHK("jump met", 1'b1, o_jump_condition_met)
    pulse(0);
    `CHK("device_end_request clr", 1'b0, o_device_end_request)
    i_int_mask = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    `CHK("masked", 1'b0, o_int_req)
    pulse(3);
    pulse(2);
    `CHK("xfer err", 1'b1, o_int_pending[1])
    pulse(3);
    ctl(16'h1407);
    slc_modem_i.send(8'h33, 8, 1'b1, 1'b1);
    repeat (12) @(negedge i_ref_clk);
    `CHK("parity err", 1'b1, o_int_pending[1])
    pulse(0);
    pulse(3);
    ctl(16'h2004);
    i_status_line = 4'h2;
    repeat (6) @(negedge i_ref_clk);
    `CHK("status off", 1'b0, o_int_pending[2])
    i_status_line = 4'h3;
    repeat (6) @(negedge i_ref_clk);
    `CHK("status on", 1'b1, o_int_pending[2])
    pulse(3);
    ctl(16'h1017);
    wr(16'h3d5a);
    slc_modem_i.get(c, p, s, 8);
    `CHK("tx upper", 8'h3d, c)
    `CHK("tx parity", ^8'h3d, p)
    `CHK("tx stop", 1'b1, s)
    slc_modem_i.get(c, p, s, 8);
    `CHK("tx lower", 8'h5a, c)
    ctl(16'h1007);
    wr(16'h3d5b);
    slc_modem_i.get(c, p, s, 8);
    `CHK("tx only low", 8'h5b, c)
    for (z = 0; z < 400 && o_tx_busy !== 1'b0; z++) @(negedge i_ref_clk);
    z = 0;
    repeat (40)
    begin
      @(negedge i_ref_clk);
      z = z + ((o_tx_data !== 1'b1) ? 1 : 0);
    end
    `CHK("no upper sent", 0, z)
    ctl(16'h1027);
    fork
      slc_modem_i.send(8'hc3, 8, 1'b1, 1'b0);
      slc_modem_i.get(c, p, s, 8);
    join
    `CHK("echo", 8'hc3, c)
    pulse(0);
    ctl(16'h1003);
    pulse(4);
    slc_modem_i.send(8'h41, 8, 1'b0, 1'b0);
    repeat (12) @(negedge i_ref_clk);
    `CHK("hunting", 1'b0, o_rx_word_ready)
    fork
      begin
        slc_modem_i.send(8'h16, 8, 1'b0, 1'b0);
        slc_modem_i.send(8'h42, 8, 1'b0, 1'b0);
        repeat (2) slc_modem_i.send(8'h16, 8, 1'b0, 1'b0);
      end
      begin
        for (z = 0; z < 200 && o_rx_word_ready !== 1'b1; z++) @(negedge i_ref_clk);
        `CHK("sync word", 16'h0042, o_read_word)
      end
    join
    end_sim();
  end
endmodule
